// ===== hw/ipt_pkg.sv
// Constants, state types and CRC step shared by the I2C packet target
package ipt_pkg;
    localparam logic [6:0]  TGT_ADDR  = 7'h01;   // Bus target identifier
    localparam int          CW_DIR    = 23;      // Op direction bit
    localparam int          CW_CRC    = 22;      // Check enable bit
    localparam int          CW_LEN    = 20;      // Low bit of payload length code
    localparam logic [1:0]  LEN_16    = 2'h0;
    localparam logic [1:0]  LEN_32    = 2'h1;
    localparam logic [1:0]  LEN_64    = 2'h2;
    localparam logic [19:0] ADDR_STEP = 20'h2;   // Second word of a 64-bit access
    localparam logic [7:0]  CRC_INIT  = 8'hff;
    localparam logic [7:0]  CRC_POLY  = 8'h07;   // x^8 + x^2 + x + 1
    localparam logic [3:0]  CW_BYTES  = 4'h4;    // Address byte plus control word
    localparam logic [3:0]  MAX_BYTES = 4'hc;    // Address, word and 8 data bytes

    typedef enum logic [4:0] {
        L_IDLE  = 5'h01,
        L_RX    = 5'h02,
        L_ACK   = 5'h04,
        L_TX    = 5'h08,
        L_TXACK = 5'h10
    } ipt_link_t;

    typedef enum logic [4:0] {
        P_IDLE = 5'h01,
        P_WR2  = 5'h02,
        P_RDW1 = 5'h04,
        P_RDW2 = 5'h08,
        P_FILL = 5'h10
    } ipt_proc_t;

    // One byte through the CRC register, MSB first
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++)
            r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        return r;
    endfunction : crc_step
endpackage : ipt_pkg

// ===== hw/ipt_target.sv
// I2C packet target: link engine, ping-pong buffers and request executor
// Overview of operation
// - Payload LSB first, count matches length
// - 16/32-bit write goes to word address
// - 64-bit write: second word at address+2
// - 64-bit read: second word from address+2
// - Device appends check byte on reads
// - CRC-8 poly 0x07, preset 0xFF
// - Bad check drops whole write
// - NACK read address until data ready
// - Two ping-pong receive buffers
// - NACK write address when both receive buffers full
// - Reads wait while both transmit buffers full
// - Release after full read, else resend
// - Control word field layout
// - Length code 00/01/10, 11 reserved
`timescale 1ns/1ps
`default_nettype none
module ipt_target (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Open-drain I2C pins
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOeN,
    // Internal memory port
    output logic             memWr,
    output logic             memRd,
    output logic [19:0]      memAddr,
    output logic [31:0]      memWdata,
    input  wire logic [31:0] memRdata,
    input  wire logic        memRdValid
);
    ipt_pkg::ipt_link_t lSt_r;
    ipt_pkg::ipt_proc_t pSt_r;
    logic [2:0]  sclQ_r, sdaQ_r;
    logic        sclF_r, sdaF_r, sdaOut_r, sdaOeN_r, byteEnd_r, ackGo_r;
    logic        isRead_r, inWrite_r, memWr_r, memRd_r;
    logic [2:0]  bitCnt_r;
    logic [7:0]  sh_r, txSh_r, crc_r;
    logic [3:0]  byteIdx_r, txByte_r;
    logic [23:0] colCw_r;
    logic [63:0] colData_r;
    logic [19:0] memAddr_r;
    logic [31:0] memWdata_r, rdLo_r, rdHi_r;
    logic [23:0] rxCw_r [2];
    logic [63:0] rxData_r [2];
    logic [3:0]  rxCnt_r [2];
    logic [1:0]  rxOk_r, rxValid_r, txValid_r;
    logic        rxWrPtr_r, rxRdPtr_r, txWrPtr_r, txRdPtr_r;
    logic [71:0] txMem_r [2];
    logic [3:0]  txLen_r [2];

    // Glitch filter: a level counts once stages two and three agree
    wire sclNxt = (sclQ_r[1] == sclQ_r[2]) ? sclQ_r[2] : sclF_r;
    wire sdaNxt = (sdaQ_r[1] == sdaQ_r[2]) ? sdaQ_r[2] : sdaF_r;
    wire sclRise = sclNxt & ~sclF_r;
    wire sclFall = ~sclNxt & sclF_r;
    wire startDet = sclF_r & sclNxt & sdaF_r & ~sdaNxt;
    wire stopDet = sclF_r & sclNxt & ~sdaF_r & sdaNxt;

    // Byte decode and acknowledge decision
    wire [7:0] rxByte = {sh_r[6:0], sdaNxt};
    wire byteDone = (lSt_r == ipt_pkg::L_RX) && sclRise && (bitCnt_r == 3'h7);
    wire addrHit = (rxByte[7:1] == ipt_pkg::TGT_ADDR);
    wire rxFull = &rxValid_r;
    wire txFull = &txValid_r;
    wire txReady = txValid_r[txRdPtr_r];
    wire ackDecide = (byteIdx_r == 4'h0) ? addrHit && (rxByte[0] ? txReady : !rxFull)
                                         : (byteIdx_r < ipt_pkg::MAX_BYTES);
    wire [3:0] dIdx = byteIdx_r - ipt_pkg::CW_BYTES;
    wire [7:0] txCur = txMem_r[txRdPtr_r][{txByte_r[3:0], 3'h0} +: 8];
    wire txLast = (txByte_r == txLen_r[txRdPtr_r]);
    wire txRel = (lSt_r == ipt_pkg::L_TXACK) && sclRise && txLast;
    wire rxPush = (startDet | stopDet) && inWrite_r && (byteIdx_r >= ipt_pkg::CW_BYTES);

    // Head of the receive queue
    wire [23:0] hdCw = rxCw_r[rxRdPtr_r];
    wire [63:0] hdData = rxData_r[rxRdPtr_r];
    wire [1:0] hdLen = hdCw[ipt_pkg::CW_LEN +: 2];
    wire hdCrc = hdCw[ipt_pkg::CW_CRC];
    wire hdRead = hdCw[ipt_pkg::CW_DIR];
    wire [19:0] hdAddr = hdCw[19:0];
    wire [3:0] nBytes = (hdLen == ipt_pkg::LEN_16) ? 4'h2 : (hdLen == ipt_pkg::LEN_32) ? 4'h4
                                                                                   : 4'h8;
    wire lenBad = (hdLen != ipt_pkg::LEN_16) && (hdLen != ipt_pkg::LEN_32)
                  && (hdLen != ipt_pkg::LEN_64);
    wire cntBad = (rxCnt_r[rxRdPtr_r] != ipt_pkg::CW_BYTES + nBytes + {3'h0, hdCrc});
    wire crcBad = hdCrc && !rxOk_r[rxRdPtr_r];
    wire headValid = rxValid_r[rxRdPtr_r];
    wire dropHead = lenBad || (!hdRead && (cntBad || crcBad));
    wire len64 = (hdLen == ipt_pkg::LEN_64);
    wire [31:0] wrWord = (hdLen == ipt_pkg::LEN_16) ? {16'h0, hdData[15:0]} : hdData[31:0];
    wire [63:0] rdData = (hdLen == ipt_pkg::LEN_16) ? {48'h0, rdLo_r[15:0]} :
                         (hdLen == ipt_pkg::LEN_32) ? {32'h0, rdLo_r} : {rdHi_r, rdLo_r};
    wire [7:0] crcRd = crc_read(hdCw, rdData, nBytes);
    wire [71:0] fillVec = {8'h0, rdData} | (hdCrc ? (72'(crcRd) << {nBytes, 3'h0}) : 72'h0);
    wire rxRel = (pSt_r == ipt_pkg::P_IDLE && headValid && dropHead)
                 || (pSt_r == ipt_pkg::P_IDLE && headValid && !hdRead && !len64)
                 || pSt_r == ipt_pkg::P_WR2 || pSt_r == ipt_pkg::P_FILL;
    wire txPush = (pSt_r == ipt_pkg::P_FILL);

    // Check over the read reply: write address byte, word, read address byte, then data
    function automatic logic [7:0] crc_read(input logic [23:0] cw, input logic [63:0] d,
                                            input logic [3:0] n);
        logic [103:0] m;
        logic [7:0]   c;
        m = {d, ipt_pkg::TGT_ADDR, 1'b1, cw[7:0], cw[15:8], cw[23:16], ipt_pkg::TGT_ADDR, 1'b0};
        c = ipt_pkg::CRC_INIT;
        for (int k = 0; k < 13; k++)
            if (k < 5 + int'(n))
                c = ipt_pkg::crc_step(c, m[8*k +: 8]);
        return c;
    endfunction : crc_read

    // Pin synchronisers
    always_ff @(posedge clk)
    begin
        sclQ_r <= rst ? 3'h7 : {sclQ_r[1:0], sclIn};
        sdaQ_r <= rst ? 3'h7 : {sdaQ_r[1:0], sdaIn};
        sclF_r <= rst ? 1'b1 : sclNxt;
        sdaF_r <= rst ? 1'b1 : sdaNxt;
        sdaOut_r <= 1'b0;                                 // Open drain only ever pulls low
    end

    // Link engine: bits, acknowledge and byte collection
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lSt_r <= ipt_pkg::L_IDLE;
            sdaOeN_r <= 1'b1;
            {byteEnd_r, ackGo_r, isRead_r, inWrite_r} <= 4'h0;
            {bitCnt_r, byteIdx_r, txByte_r} <= 11'h0;
            {sh_r, txSh_r, crc_r} <= 24'h0;
            colCw_r <= 24'h0;
            colData_r <= 64'h0;
        end
        else if (startDet || stopDet)
        begin
            lSt_r <= startDet ? ipt_pkg::L_RX : ipt_pkg::L_IDLE;
            sdaOeN_r <= 1'b1;
            {byteEnd_r, inWrite_r} <= 2'h0;
            bitCnt_r <= 3'h0;
            byteIdx_r <= 4'h0;
        end
        else
            case (lSt_r)
                ipt_pkg::L_RX:
                    if (sclRise)
                    begin
                        sh_r <= rxByte;
                        bitCnt_r <= bitCnt_r + 3'h1;
                        if (byteDone)
                        begin
                            byteEnd_r <= 1'b1;
                            ackGo_r <= ackDecide;
                            if (byteIdx_r != 4'hf)
                                byteIdx_r <= byteIdx_r + 4'h1;
                            crc_r <= ipt_pkg::crc_step((byteIdx_r == 4'h0) ? ipt_pkg::CRC_INIT
                                                                          : crc_r, rxByte);
                            if (byteIdx_r == 4'h0)
                            begin
                                isRead_r <= rxByte[0];
                                inWrite_r <= ackDecide && !rxByte[0];
                                txByte_r <= 4'h0;
                                colData_r <= 64'h0;
                            end
                            else if (byteIdx_r < ipt_pkg::CW_BYTES)
                                colCw_r <= {colCw_r[15:0], rxByte};
                            else if (byteIdx_r < ipt_pkg::MAX_BYTES)
                                colData_r[{dIdx[2:0], 3'h0} +: 8] <= rxByte;
                        end
                    end
                    else if (sclFall && byteEnd_r)
                    begin
                        byteEnd_r <= 1'b0;
                        sdaOeN_r <= !ackGo_r;
                        lSt_r <= ackGo_r ? ipt_pkg::L_ACK : ipt_pkg::L_IDLE;
                    end
                ipt_pkg::L_ACK, ipt_pkg::L_TXACK:
                    if (sclRise && lSt_r == ipt_pkg::L_TXACK)
                        ackGo_r <= !sdaNxt && !txLast;    // Host NACK or last byte ends it
                    else if (sclFall)
                    begin
                        bitCnt_r <= 3'h0;
                        if (isRead_r && (lSt_r == ipt_pkg::L_ACK || ackGo_r))
                        begin
                            sdaOeN_r <= txCur[7];
                            txSh_r <= {txCur[6:0], 1'b0};
                            lSt_r <= ipt_pkg::L_TX;
                        end
                        else
                        begin
                            sdaOeN_r <= 1'b1;
                            lSt_r <= isRead_r ? ipt_pkg::L_IDLE : ipt_pkg::L_RX;
                        end
                    end
                ipt_pkg::L_TX:
                    if (sclRise)
                    begin
                        bitCnt_r <= bitCnt_r + 3'h1;
                        byteEnd_r <= (bitCnt_r == 3'h7);
                    end
                    else if (sclFall && byteEnd_r)
                    begin
                        byteEnd_r <= 1'b0;
                        sdaOeN_r <= 1'b1;
                        txByte_r <= txByte_r + 4'h1;
                        lSt_r <= ipt_pkg::L_TXACK;
                    end
                    else if (sclFall)
                    begin
                        sdaOeN_r <= txSh_r[7];
                        txSh_r <= {txSh_r[6:0], 1'b0};
                    end
                default:
                    lSt_r <= ipt_pkg::L_IDLE;
            endcase
    end

    // Receive ping-pong: link fills one entry while the executor drains the other
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rxValid_r <= 2'h0;
            {rxWrPtr_r, rxRdPtr_r} <= 2'h0;
        end
        else
        begin
            if (rxPush)
            begin
                rxCw_r[rxWrPtr_r] <= colCw_r;
                rxData_r[rxWrPtr_r] <= colData_r;
                rxCnt_r[rxWrPtr_r] <= byteIdx_r;
                rxOk_r[rxWrPtr_r] <= (crc_r == 8'h0);
                rxWrPtr_r <= ~rxWrPtr_r;
            end
            if (rxRel)
                rxRdPtr_r <= ~rxRdPtr_r;
            for (int i = 0; i < 2; i++)
                rxValid_r[i] <= (rxPush && rxWrPtr_r == i[0])
                                || (rxValid_r[i] && !(rxRel && rxRdPtr_r == i[0]));
        end
    end

    // Transmit ping-pong: an entry frees only after its last byte went out
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            txValid_r <= 2'h0;
            {txWrPtr_r, txRdPtr_r} <= 2'h0;
        end
        else
        begin
            if (txPush)
            begin
                txMem_r[txWrPtr_r] <= fillVec;
                txLen_r[txWrPtr_r] <= nBytes + {3'h0, hdCrc};
                txWrPtr_r <= ~txWrPtr_r;
            end
            if (txRel)
                txRdPtr_r <= ~txRdPtr_r;
            for (int i = 0; i < 2; i++)
                txValid_r[i] <= (txPush && txWrPtr_r == i[0])
                                || (txValid_r[i] && !(txRel && txRdPtr_r == i[0]));
        end
    end

    // Executor: one request at a time from the head of the receive queue
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pSt_r <= ipt_pkg::P_IDLE;
            {memWr_r, memRd_r} <= 2'h0;
            memAddr_r <= 20'h0;
            {memWdata_r, rdLo_r, rdHi_r} <= 96'h0;
        end
        else
        begin
            memWr_r <= 1'b0;
            memRd_r <= 1'b0;
            case (pSt_r)
                ipt_pkg::P_IDLE:
                    if (headValid && !dropHead && !hdRead)
                    begin
                        memWr_r <= 1'b1;
                        memAddr_r <= hdAddr;
                        memWdata_r <= wrWord;
                        pSt_r <= len64 ? ipt_pkg::P_WR2 : ipt_pkg::P_IDLE;
                    end
                    else if (headValid && !dropHead && !txFull)
                    begin
                        memRd_r <= 1'b1;
                        memAddr_r <= hdAddr;
                        pSt_r <= ipt_pkg::P_RDW1;
                    end
                ipt_pkg::P_WR2:
                begin
                    memWr_r <= 1'b1;
                    memAddr_r <= memAddr_r + ipt_pkg::ADDR_STEP;
                    memWdata_r <= hdData[63:32];
                    pSt_r <= ipt_pkg::P_IDLE;
                end
                ipt_pkg::P_RDW1:
                    if (memRdValid)
                    begin
                        rdLo_r <= memRdata;
                        memRd_r <= len64;
                        memAddr_r <= len64 ? memAddr_r + ipt_pkg::ADDR_STEP : memAddr_r;
                        pSt_r <= len64 ? ipt_pkg::P_RDW2 : ipt_pkg::P_FILL;
                    end
                ipt_pkg::P_RDW2:
                    if (memRdValid)
                    begin
                        rdHi_r <= memRdata;
                        pSt_r <= ipt_pkg::P_FILL;
                    end
                default:
                    pSt_r <= ipt_pkg::P_IDLE;
            endcase
        end
    end

    assign sdaOut = sdaOut_r;
    assign sdaOeN = sdaOeN_r;
    assign memWr = memWr_r;
    assign memRd = memRd_r;
    assign memAddr = memAddr_r;
    assign memWdata = memWdata_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_NACK_FULL: assert property (byteDone && byteIdx_r == 4'h0 && !rxByte[0] && rxFull
        |=> !ackGo_r ##0 sdaOeN_r [*8] ##1 sdaOeN_r [*8])
        else $error("address acked with both receive buffers full");
    AST_NACK_NOTX: assert property (byteDone && byteIdx_r == 4'h0 && rxByte[0] && !txReady
        |=> !ackGo_r) else $error("read address acked without reply");
    AST_WR_STEP: assert property (pSt_r == ipt_pkg::P_WR2
        |=> memWr_r && memAddr_r == $past(memAddr_r) + ipt_pkg::ADDR_STEP)
        else $error("second write address");
    AST_RD_STEP: assert property (pSt_r == ipt_pkg::P_RDW2 && $rose(pSt_r == ipt_pkg::P_RDW2)
        |-> memRd_r && memAddr_r == hdAddr + ipt_pkg::ADDR_STEP) else $error("second read address");
    AST_DROP: assert property (pSt_r == ipt_pkg::P_IDLE && headValid && dropHead
        |=> !memWr_r && !memRd_r && rxRdPtr_r != $past(rxRdPtr_r))
        else $error("dropped request touched memory");
    AST_TX_HOLD: assert property (pSt_r == ipt_pkg::P_IDLE && headValid && hdRead && txFull
        |=> !memRd_r) else $error("read executed with transmit buffers full");
    AST_CRC_PRESET: assert property (byteDone && byteIdx_r == 4'h0
        |=> crc_r == ipt_pkg::crc_step(ipt_pkg::CRC_INIT, $past(rxByte))) else $error("crc preset");
    AST_PUSH: assert property (rxPush |=> rxValid_r[$past(rxWrPtr_r)] && rxWrPtr_r != $past(rxWrPtr_r))
        else $error("request not captured");
    AST_REWIND: assert property (byteDone && byteIdx_r == 4'h0 && rxByte[0] && addrHit
        |=> txByte_r == 4'h0) else $error("read does not restart at first byte");
    COV_WRITE: cover property (memWr_r ##1 memWr_r);
    COV_FILL: cover property (txPush && hdCrc);
    COV_FULL: cover property (byteDone && byteIdx_r == 4'h0 && rxFull);
    COV_RELEASE: cover property (txRel);
endmodule : ipt_target
`default_nettype wire

// ===== bench/ipt_host_model.sv
// I2C controller model that drives the packet target from the bus side
`timescale 1ns/1ps
`default_nettype none
module ipt_host_model (
    // Clock
    input  wire logic clk,
    // Bus lines, data is open drain with a pull-up
    input  wire logic sdaWire,
    output logic      scl,
    output logic      sdaDrvN
);
    // 160 ns link period: a quarter low, a half high, a quarter low
    localparam int HALF = 8;
    localparam int QTR  = 4;

    // Idle bus; SCL stands high between frames
    initial
    begin
        scl     = 1'b1;
        sdaDrvN = 1'b1;
    end

    task automatic waitHalf();
        repeat (HALF) @(negedge clk);
    endtask : waitHalf

    task automatic waitQtr();
        repeat (QTR) @(negedge clk);
    endtask : waitQtr

    // Start or repeated start
    task automatic start();
        sdaDrvN = 1'b1;
        waitHalf();
        scl = 1'b1;
        waitHalf();
        sdaDrvN = 1'b0;
        waitHalf();
        scl = 1'b0;
        waitHalf();
    endtask : start

    task automatic stop();
        sdaDrvN = 1'b0;
        waitHalf();
        scl = 1'b1;
        waitHalf();
        sdaDrvN = 1'b1;
        waitHalf();
    endtask : stop

    // Data moves a quarter after the fall, so the target's hold is safe
    task automatic bitOut(input logic b);
        sdaDrvN = b;
        waitQtr();
        scl = 1'b1;
        waitHalf();
        scl = 1'b0;
        waitQtr();
    endtask : bitOut

    task automatic bitIn(output logic b);
        sdaDrvN = 1'b1;
        waitQtr();
        scl = 1'b1;
        waitHalf();
        b   = sdaWire;
        scl = 1'b0;
        waitQtr();
    endtask : bitIn

    // Byte out MSB first, then the target's acknowledge
    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic nak;
        for (int i = 7; i >= 0; i--)
            bitOut(d[i]);
        bitIn(nak);
        ack = ~nak;
        waitHalf(); // Byte gap, scaled down to keep the run short
    endtask : sendByte

    // Byte in; every byte but the last is acknowledged
    task automatic recvByte(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--)
            bitIn(d[i]);
        bitOut(last);
        waitHalf();
    endtask : recvByte
endmodule : ipt_host_model
`default_nettype wire

// ===== bench/ipt_target_test.sv
// Self-checking bench for the I2C packet target with host and memory models
`timescale 1ns/1ps
`default_nettype none
module ipt_target_test;
    logic        clk;
    logic        rst;
    logic        scl;
    logic        hostDrvN;
    logic        sdaLine;
    logic        sdaOut;
    logic        sdaOeN;
    logic        memWr;
    logic        memRd;
    logic [19:0] memAddr;
    logic [31:0] memWdata;
    logic [31:0] memRdata;
    logic        memRdValid;
    logic [19:0] rdAddr = 20'h0;
    logic [19:0] wrAddrQ [$];
    logic [31:0] wrDataQ [$];
    int          memLat;
    int          latCnt = 0;
    int          error_cnt;
    int          tests_run;

    function automatic logic [31:0] memWord(input logic [19:0] a);
        return {12'h5a0, a};
    endfunction : memWord

    // Own model of the check register, MSB first
    function automatic logic [7:0] crcNext(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++)
            r = {r[6:0], 1'b0} ^ (r[7] ? 8'h07 : 8'h00);
        return r;
    endfunction : crcNext

    // Wired-AND data line: target pulls low only with its enable low
    assign sdaLine  = hostDrvN & (sdaOeN | sdaOut);
    assign memRdata = memWord(rdAddr);

    ipt_target uut (.clk(clk), .rst(rst), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOeN(sdaOeN), .memWr(memWr), .memRd(memRd), .memAddr(memAddr),
        .memWdata(memWdata), .memRdata(memRdata), .memRdValid(memRdValid));
    ipt_host_model host (.clk(clk), .sdaWire(sdaLine), .scl(scl), .sdaDrvN(hostDrvN));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    // Memory side: log writes, answer each read after memLat cycles
    always @(negedge clk)
    begin
        memRdValid <= 1'b0;
        if (memWr)
        begin
            wrAddrQ.push_back(memAddr);
            wrDataQ.push_back(memWdata);
        end
        if (memRd)
        begin
            rdAddr <= memAddr;
            latCnt <= memLat;
        end
        else if (latCnt > 0)
            latCnt <= latCnt - 1;
        if (!memRd && latCnt == 1)
            memRdValid <= 1'b1;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    // Whole request: address, control word, payload LSB first, optional check
    task automatic sendReq(input logic [23:0] cw, input logic [63:0] d, input int n,
                           input logic [7:0] flip, output logic addrAck);
        logic [7:0] c;
        logic       ack;
        logic [7:0] b [$];
        c = 8'hff;
        b = {8'h02, cw[23:16], cw[15:8], cw[7:0]};
        for (int i = 0; i < n; i++)
            b.push_back(d[8*i +: 8]);
        host.start();
        foreach (b[i])
        begin
            host.sendByte(b[i], ack);
            if (i == 0)
                addrAck = ack;
            c = crcNext(c, b[i]);
        end
        if (cw[22] && n > 0)
            host.sendByte(c ^ flip, ack);
        host.stop();
    endtask : sendReq

    // Bare read address, then up to upTo reply bytes
    task automatic readReply(input logic [23:0] cw, input int upTo, output logic ack);
        logic [7:0]  c;
        logic [7:0]  got;
        logic [63:0] exp;
        int          n;
        n   = 2 << cw[21:20];
        exp = {memWord(cw[19:0] + 20'h2), memWord(cw[19:0])};
        c   = crcNext(crcNext(crcNext(crcNext(8'hff, 8'h02), cw[23:16]), cw[15:8]), cw[7:0]);
        c   = crcNext(c, 8'h03);
        host.start();
        host.sendByte(8'h03, ack);
        for (int i = 0; ack && i < upTo; i++)
        begin
            host.recvByte(got, i == upTo - 1);
            if (i < n)
            begin
                check("read byte", {24'h0, got}, {24'h0, exp[8*i +: 8]});
                c = crcNext(c, exp[8*i +: 8]);
            end
            else
                check("read check", {24'h0, got}, {24'h0, c});
        end
        host.stop();
    endtask : readReply

    // Retry the bare read address until the reply is ready
    task automatic readUntil(input logic [23:0] cw, output int tries);
        logic ack;
        ack   = 1'b0;
        tries = 0;
        while (!ack && tries < 40)
        begin
            tries++;
            readReply(cw, (2 << cw[21:20]) + cw[22], ack);
        end
        if (!ack)
        begin
            error_cnt++;
            $display("BAD read reply expected ack seen nack");
            complete_run();
        end
    endtask : readUntil

    task automatic chkWr(input logic [19:0] a, input logic [31:0] d);
        check("write count", 32'(wrAddrQ.size() > 0), 32'h1);
        if (wrAddrQ.size() > 0)
        begin
            check("write addr", {12'h0, wrAddrQ.pop_front()}, {12'h0, a});
            check("write data", wrDataQ.pop_front(), d);
        end
    endtask : chkWr

    task automatic testWrites();
        logic ack;
        sendReq(24'h500080, 64'h1234abcd, 4, 8'h00, ack);
        sendReq(24'h2357fe, 64'h89abcdef01234567, 8, 8'h00, ack);
        sendReq(24'h0a0010, 64'hbeef, 2, 8'h00, ack);
        repeat (20) @(negedge clk);
        chkWr(20'h00080, 32'h1234abcd);
        chkWr(20'h357fe, 32'h01234567);
        chkWr(20'h35800, 32'h89abcdef);
        chkWr(20'ha0010, 32'h0000beef);
        $display("done writes");
    endtask : testWrites

    // Bad check, reserved length and short payload all leave memory alone
    task automatic testDrops();
        logic ack;
        sendReq(24'h500100, 64'h55aa55aa, 4, 8'h01, ack);
        sendReq(24'h300200, 64'h11223344, 4, 8'h00, ack);
        sendReq(24'h100300, 64'h000001, 3, 8'h00, ack);
        sendReq(24'hb00400, 64'h0, 0, 8'h00, ack);
        readReply(24'hb00400, 1, ack);
        check("reserved read ack", {31'h0, ack}, 32'h0);
        repeat (20) @(negedge clk);
        check("writes left", 32'(wrAddrQ.size()), 32'h0);
        $display("done drops");
    endtask : testDrops

    // Slow memory forces a NACK of the first read address
    task automatic testRead();
        logic ack;
        int   tries;
        memLat = 600;
        sendReq(24'he120f0, 64'h0, 0, 8'h00, ack);
        readUntil(24'he120f0, tries);
        check("read retried", 32'(tries > 1), 32'h1);
        memLat = 2;
        sendReq(24'h800010, 64'h0, 0, 8'h00, ack);
        readUntil(24'h800010, tries);
        $display("done reads");
    endtask : testRead

    task automatic testResend();
        logic ack;
        int   tries;
        sendReq(24'hd00080, 64'h0, 0, 8'h00, ack);
        readReply(24'hd00080, 2, ack);
        check("early read ack", {31'h0, ack}, 32'h1);
        readUntil(24'hd00080, tries);
        readReply(24'hd00080, 1, ack);
        check("released ack", {31'h0, ack}, 32'h0);
        $display("done resend");
    endtask : testResend

    // Two unread replies fill the transmit pair, so a third read must wait
    task automatic testTxFull();
        logic ack;
        int   tries;
        sendReq(24'h900050, 64'h0, 0, 8'h00, ack);
        sendReq(24'h900060, 64'h0, 0, 8'h00, ack);
        sendReq(24'h900070, 64'h0, 0, 8'h00, ack);
        repeat (20) @(negedge clk);
        check("held read", {12'h0, rdAddr}, 32'h00000060);
        readUntil(24'h900050, tries);
        readUntil(24'h900060, tries);
        readUntil(24'h900070, tries);
        $display("done transmit pair");
    endtask : testTxFull

    // A stalled read holds one receive buffer, a write fills the other
    task automatic testFull();
        logic ack;
        int   tries;
        memLat = 6000;
        sendReq(24'h900040, 64'h0, 0, 8'h00, ack);
        sendReq(24'h100300, 64'hcafe0001, 4, 8'h00, ack);
        check("second ack", {31'h0, ack}, 32'h1);
        sendReq(24'h100302, 64'h0bad0bad, 4, 8'h00, ack);
        check("third ack", {31'h0, ack}, 32'h0);
        readUntil(24'h900040, tries);
        repeat (20) @(negedge clk);
        chkWr(20'h00300, 32'hcafe0001);
        check("writes left", 32'(wrAddrQ.size()), 32'h0);
        $display("done full buffers");
    endtask : testFull

    initial
    begin
        rst        = 1'b1;
        memLat     = 2;
        error_cnt  = 0;
        tests_run  = 0;
        repeat (5) @(negedge clk);
        check("idle pins", {28'h0, sdaOut, sdaOeN, memWr, memRd}, 32'h4);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        testWrites();
        testDrops();
        testRead();
        testResend();
        testTxFull();
        testFull();
        complete_run();
    end

    // Cut a hang short
    initial
    begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        $display("BAD run length expected end seen limit");
        complete_run();
    end
endmodule : ipt_target_test
`default_nettype wire
